/* include/psd_pkg.sv */
// constants, operation codes and carriers of the packed integer datapath
package psd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PSD_B    = 8;   // byte lane
  localparam int PSD_H    = 16;  // word lane
  localparam int PSD_D    = 32;  // doubleword lane
  localparam int PSD_Q    = 64;  // quadword operand
  localparam int PSD_NREG = 8;   // packed registers
  localparam int PSD_RW   = 3;   // register index width

  // ----------------------------------------------------------------
  // lane modes
  // ----------------------------------------------------------------
  localparam logic [1:0] PSD_SAT_NONE = 2'h0; // wrapping
  localparam logic [1:0] PSD_SAT_S    = 2'h1; // signed clamp
  localparam logic [1:0] PSD_SAT_U    = 2'h2; // unsigned clamp
  localparam logic [1:0] PSD_MUL_HI   = 2'h0; // keep high half
  localparam logic [1:0] PSD_MUL_LO   = 2'h1; // keep low half
  localparam logic [1:0] PSD_MUL_SUM  = 2'h2; // sum product pairs
  localparam logic [63:0] PSD_RST_REG = 64'h0000000000000000;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    move_dword, move_qword, move_dword_store, move_qword_store,
    pack_w2b_signed_sat, pack_d2w_signed_sat, pack_w2b_unsigned_sat,
    interleave_high_bytes, interleave_high_words, interleave_high_dwords,
    interleave_low_bytes, interleave_low_words, interleave_low_dwords,
    lane_add_bytes, lane_add_words, lane_add_dwords,
    lane_add_bytes_ssat, lane_add_words_ssat,
    lane_add_bytes_usat, lane_add_words_usat,
    lane_sub_bytes, lane_sub_words, lane_sub_dwords,
    lane_sub_bytes_ssat, lane_sub_words_ssat,
    lane_sub_bytes_usat, lane_sub_words_usat,
    mul_words_keep_high, mul_words_keep_low, mul_words_sum_pairs,
    cmp_equal_bytes, cmp_equal_words, cmp_equal_dwords,
    cmp_greater_bytes, cmp_greater_words, cmp_greater_dwords,
    quad_bitwise_and, quad_bitwise_andnot, quad_bitwise_or, quad_bitwise_xor,
    shift_left_words, shift_left_dwords, shift_left_qword,
    shift_right_words, shift_right_dwords, shift_right_qword,
    shift_right_arith_words, shift_right_arith_dwords,
    empty_packed_state
  } psd_op_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;    // issue this cycle
    psd_op_t           op;       // operation
    logic [PSD_RW-1:0] dst;      // destination, also first operand
    logic [PSD_RW-1:0] src;      // second operand register
    logic              src_mem;  // second operand from memory
    logic [63:0]       mem_data; // memory operand
  } psd_req_t;

  typedef struct packed {
    logic              valid;    // result present
    logic              store;    // data goes to memory
    logic [PSD_RW-1:0] dst;      // register written
    logic [63:0]       data;     // result
  } psd_res_t;

endpackage

/* logic/psd_datapath.sv */
// packed integer simd datapath with its register file
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - moves copy dword or qword, register or memory
// - word to signed byte pack clamps
// - dword to signed word pack clamps
// - word to unsigned byte pack clamps 0..255
// - high unpack interleaves upper lanes
// - low unpack interleaves lower lanes
// - plain add per lane, no carries across
// - signed saturating add clamps both ends
// - unsigned saturating add clamps at maximum
// - plain subtract per lane, no borrows across
// - signed saturating subtract clamps to range
// - unsigned saturating subtract clamps at zero
// - signed word multiply keeps high half
// - signed word multiply keeps low half
// - multiply words, sum adjacent pairs to dwords
// - equality compare per lane
// - signed greater-than compare per lane
// - quadword and, andnot, or, xor
// - logical shifts fill with zeros
// - arithmetic right shifts fill with sign
// - all operands are 64 bits
// - empty operation clears register state
module psd_datapath
  import psd_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     nrst,
  // request from decoder
  input  wire psd_req_t req,
  // result and state
  output psd_res_t      res,
  output logic          regs_empty
);

  // ----------------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------------
  // mask of w low bits
  function automatic logic [63:0] f_mask(input int w);
    f_mask = (w >= PSD_Q) ? '1 : ((64'h1 << w) - 64'h1);
  endfunction

  // lane i of width w, zero extended
  function automatic logic [63:0] f_lane(input logic [63:0] v, input int w,
                                        input int i);
    f_lane = (v >> (i * w)) & f_mask(w);
  endfunction

  // sign extend a w-bit lane value
  function automatic logic signed [64:0] f_sx(input logic [63:0] v,
                                              input int w);
    f_sx = $signed({1'b0, v});
    if (v[w-1]) begin
      f_sx = f_sx - (65'sh1 <<< w);
    end
  endfunction

  // add or subtract lanes, wrapping or clamped
  function automatic logic [63:0] f_arith(input logic [63:0] a, b,
                                         input int w, input logic sub,
                                         input logic [1:0] sat);
    logic signed [64:0] x, y, s, hi, lo;
    logic [63:0]        r;
    r = '0;
    for (int i = 0; i < PSD_Q / w; i++) begin
      x  = (sat == PSD_SAT_S) ? f_sx(f_lane(a, w, i), w)
                              : $signed({1'b0, f_lane(a, w, i)});
      y  = (sat == PSD_SAT_S) ? f_sx(f_lane(b, w, i), w)
                              : $signed({1'b0, f_lane(b, w, i)});
      s  = sub ? x - y : x + y;
      hi = (sat == PSD_SAT_S) ? (65'sh1 <<< (w - 1)) - 65'sh1
                              : $signed({1'b0, f_mask(w)});
      lo = (sat == PSD_SAT_S) ? -(65'sh1 <<< (w - 1)) : 65'sh0;
      // clamp only in the saturating forms
      if (sat != PSD_SAT_NONE) begin
        if (s > hi) begin
          s = hi;
        end
        if (s < lo) begin
          s = lo;
        end
      end
      // masking drops the carry out of each lane
      r = r | ((s[63:0] & f_mask(w)) << (i * w));
    end
    f_arith = r;
  endfunction

  // per-lane compare: all ones when true
  function automatic logic [63:0] f_cmp(input logic [63:0] a, b,
                                       input int w, input logic gt);
    logic signed [64:0] x, y;
    logic [63:0]        r;
    r = '0;
    for (int i = 0; i < PSD_Q / w; i++) begin
      x = f_sx(f_lane(a, w, i), w);
      y = f_sx(f_lane(b, w, i), w);
      if (gt ? (x > y) : (x == y)) begin
        r = r | (f_mask(w) << (i * w));
      end
    end
    f_cmp = r;
  endfunction

  // lane shifts; count from the whole second operand
  function automatic logic [63:0] f_shift(input logic [63:0] a, cnt,
                                         input int w, input logic right,
                                         input logic arith);
    logic [63:0]        x, r;
    logic signed [64:0] sx;
    int                 c;
    r = '0;
    for (int i = 0; i < PSD_Q / w; i++) begin
      x = f_lane(a, w, i);
      if (arith) begin
        // large counts leave only copies of the sign
        c  = (cnt >= 64'(w)) ? w - 1 : int'(cnt[6:0]);
        sx = f_sx(x, w) >>> c;
        x  = sx[63:0];
      end else if (cnt >= 64'(w)) begin
        x = '0;
      end else begin
        x = right ? (x >> cnt) : (x << cnt);
      end
      r = r | ((x & f_mask(w)) << (i * w));
    end
    f_shift = r;
  endfunction

  // narrow lanes of a then b to half width with clamping
  function automatic logic [63:0] f_pack(input logic [63:0] a, b,
                                        input int w, input logic uns);
    logic signed [64:0] x, hi, lo;
    logic [63:0]        r;
    int                 n, h;
    r  = '0;
    n  = PSD_Q / w;
    h  = w / 2;
    hi = uns ? $signed({1'b0, f_mask(h)}) : (65'sh1 <<< (h - 1)) - 65'sh1;
    lo = uns ? 65'sh0 : -(65'sh1 <<< (h - 1));
    for (int i = 0; i < 2 * n; i++) begin
      x = f_sx(f_lane((i < n) ? a : b, w, i % n), w);
      if (x > hi) begin
        x = hi;
      end
      if (x < lo) begin
        x = lo;
      end
      r = r | ((x[63:0] & f_mask(h)) << (i * h));
    end
    f_pack = r;
  endfunction

  // interleave half of the lanes, a first then b
  function automatic logic [63:0] f_unpack(input logic [63:0] a, b,
                                          input int w, input logic high);
    logic [63:0] r;
    int          n, j;
    r = '0;
    n = PSD_Q / w / 2;
    for (int i = 0; i < n; i++) begin
      j = high ? i + n : i;
      r = r | (f_lane(a, w, j) << (2 * i * w))
            | (f_lane(b, w, j) << ((2 * i + 1) * w));
    end
    f_unpack = r;
  endfunction

  // signed word products, reduced by mode
  function automatic logic [63:0] f_mul(input logic [63:0] a, b,
                                       input logic [1:0] mode);
    logic signed [31:0] p [4];
    logic [63:0]        r;
    r = '0;
    for (int i = 0; i < PSD_Q / PSD_H; i++) begin
      p[i] = $signed(a[i*PSD_H +: PSD_H]) * $signed(b[i*PSD_H +: PSD_H]);
      if (mode == PSD_MUL_HI) begin
        r[i*PSD_H +: PSD_H] = p[i][PSD_D-1:PSD_H];
      end else begin
        r[i*PSD_H +: PSD_H] = p[i][PSD_H-1:0];
      end
    end
    if (mode == PSD_MUL_SUM) begin
      r = {32'(p[2] + p[3]), 32'(p[0] + p[1])};
    end
    f_mul = r;
  endfunction

  // ----------------------------------------------------------------
  // operands
  // ----------------------------------------------------------------
  logic [63:0] regs [PSD_NREG]; // packed register file
  logic [63:0] a;               // first operand, destination register
  logic [63:0] b;               // second operand, register or memory
  logic [63:0] next_data;       // result of this cycle's request
  logic        is_store;        // result goes to memory
  logic        writes_reg;      // result goes to register

  assign a          = regs[req.dst];
  assign b          = req.src_mem ? req.mem_data : regs[req.src];
  assign is_store   = (req.op == move_dword_store)
                   || (req.op == move_qword_store);
  assign writes_reg = req.valid && !is_store && (req.op != empty_packed_state);

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  // select the result of the requested operation
  always_comb begin
    unique case (req.op)
      move_dword, move_dword_store: next_data = {32'h00000000, b[31:0]};
      move_qword, move_qword_store: next_data = b;
      pack_w2b_signed_sat:      next_data = f_pack(a, b, PSD_H, 1'b0);
      pack_d2w_signed_sat:      next_data = f_pack(a, b, PSD_D, 1'b0);
      pack_w2b_unsigned_sat:    next_data = f_pack(a, b, PSD_H, 1'b1);
      interleave_high_bytes:    next_data = f_unpack(a, b, PSD_B, 1'b1);
      interleave_high_words:    next_data = f_unpack(a, b, PSD_H, 1'b1);
      interleave_high_dwords:   next_data = f_unpack(a, b, PSD_D, 1'b1);
      interleave_low_bytes:     next_data = f_unpack(a, b, PSD_B, 1'b0);
      interleave_low_words:     next_data = f_unpack(a, b, PSD_H, 1'b0);
      interleave_low_dwords:    next_data = f_unpack(a, b, PSD_D, 1'b0);
      lane_add_bytes:  next_data = f_arith(a, b, PSD_B, 1'b0, PSD_SAT_NONE);
      lane_add_words:  next_data = f_arith(a, b, PSD_H, 1'b0, PSD_SAT_NONE);
      lane_add_dwords: next_data = f_arith(a, b, PSD_D, 1'b0, PSD_SAT_NONE);
      lane_add_bytes_ssat: next_data = f_arith(a, b, PSD_B, 1'b0, PSD_SAT_S);
      lane_add_words_ssat: next_data = f_arith(a, b, PSD_H, 1'b0, PSD_SAT_S);
      lane_add_bytes_usat: next_data = f_arith(a, b, PSD_B, 1'b0, PSD_SAT_U);
      lane_add_words_usat: next_data = f_arith(a, b, PSD_H, 1'b0, PSD_SAT_U);
      lane_sub_bytes:  next_data = f_arith(a, b, PSD_B, 1'b1, PSD_SAT_NONE);
      lane_sub_words:  next_data = f_arith(a, b, PSD_H, 1'b1, PSD_SAT_NONE);
      lane_sub_dwords: next_data = f_arith(a, b, PSD_D, 1'b1, PSD_SAT_NONE);
      lane_sub_bytes_ssat: next_data = f_arith(a, b, PSD_B, 1'b1, PSD_SAT_S);
      lane_sub_words_ssat: next_data = f_arith(a, b, PSD_H, 1'b1, PSD_SAT_S);
      lane_sub_bytes_usat: next_data = f_arith(a, b, PSD_B, 1'b1, PSD_SAT_U);
      lane_sub_words_usat: next_data = f_arith(a, b, PSD_H, 1'b1, PSD_SAT_U);
      mul_words_keep_high: next_data = f_mul(a, b, PSD_MUL_HI);
      mul_words_keep_low:  next_data = f_mul(a, b, PSD_MUL_LO);
      mul_words_sum_pairs: next_data = f_mul(a, b, PSD_MUL_SUM);
      cmp_equal_bytes:    next_data = f_cmp(a, b, PSD_B, 1'b0);
      cmp_equal_words:    next_data = f_cmp(a, b, PSD_H, 1'b0);
      cmp_equal_dwords:   next_data = f_cmp(a, b, PSD_D, 1'b0);
      cmp_greater_bytes:  next_data = f_cmp(a, b, PSD_B, 1'b1);
      cmp_greater_words:  next_data = f_cmp(a, b, PSD_H, 1'b1);
      cmp_greater_dwords: next_data = f_cmp(a, b, PSD_D, 1'b1);
      quad_bitwise_and:    next_data = a & b;
      quad_bitwise_andnot: next_data = ~a & b;
      quad_bitwise_or:     next_data = a | b;
      quad_bitwise_xor:    next_data = a ^ b;
      shift_left_words:   next_data = f_shift(a, b, PSD_H, 1'b0, 1'b0);
      shift_left_dwords:  next_data = f_shift(a, b, PSD_D, 1'b0, 1'b0);
      shift_left_qword:   next_data = f_shift(a, b, PSD_Q, 1'b0, 1'b0);
      shift_right_words:  next_data = f_shift(a, b, PSD_H, 1'b1, 1'b0);
      shift_right_dwords: next_data = f_shift(a, b, PSD_D, 1'b1, 1'b0);
      shift_right_qword:  next_data = f_shift(a, b, PSD_Q, 1'b1, 1'b0);
      shift_right_arith_words:  next_data = f_shift(a, b, PSD_H, 1'b1, 1'b1);
      shift_right_arith_dwords: next_data = f_shift(a, b, PSD_D, 1'b1, 1'b1);
      empty_packed_state: next_data = PSD_RST_REG;
      // unused encodings give zero
      default: next_data = PSD_RST_REG;
    endcase
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // register file write-back and clearing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < PSD_NREG; i++) begin
        regs[i] <= PSD_RST_REG;
      end
    end else if (req.valid && (req.op == empty_packed_state)) begin
      for (int i = 0; i < PSD_NREG; i++) begin
        regs[i] <= PSD_RST_REG;
      end
    end else if (writes_reg) begin
      regs[req.dst] <= next_data;
    end
  end

  // empty flag: set by clearing, dropped by any register write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regs_empty <= 1'b1;
    end else if (req.valid && (req.op == empty_packed_state)) begin
      regs_empty <= 1'b1;
    end else if (writes_reg) begin
      regs_empty <= 1'b0;
    end
  end

  // registered result toward the register file and memory
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res <= '0;
    end else begin
      res.valid <= req.valid;
      res.store <= req.valid && is_store;
      res.dst   <= req.dst;
      res.data  <= next_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_move;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == move_dword |=> res.data == {32'h00000000, $past(b[31:0])};
  endproperty
  a_move: assert property (p_move) else $error("dword move wrong");

  property p_add_wrap;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == lane_add_bytes
    |=> res.data[15:8] == 8'($past(a[15:8]) + $past(b[15:8]));
  endproperty
  a_add_wrap: assert property (p_add_wrap) else $error("byte add wrong");

  property p_ssat;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == lane_add_words_ssat
    && ($signed({a[15], a[15:0]}) + $signed({b[15], b[15:0]})) < -17'sd32768
    |=> res.data[15:0] == 16'h8000;
  endproperty
  a_ssat: assert property (p_ssat) else $error("signed add not clamped");

  property p_usub;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == lane_sub_bytes_usat && a[7:0] < b[7:0] |=> res.data[7:0] == 8'h00;
  endproperty
  a_usub: assert property (p_usub) else $error("unsigned sub not zero");

  property p_mulh;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == mul_words_keep_high
    |=> res.data[31:16] == 16'((32'($signed($past(a[31:16]))) * 32'($signed($past(b[31:16])))) >>> 16);
  endproperty
  a_mulh: assert property (p_mulh) else $error("high product wrong");

  property p_cmp_eq;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == cmp_equal_dwords && a[63:32] == b[63:32]
    |=> res.data[63:32] == 32'hFFFFFFFF;
  endproperty
  a_cmp_eq: assert property (p_cmp_eq) else $error("equal lane not ones");

  property p_cmp_gt;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == cmp_greater_bytes && $signed(a[7:0]) <= $signed(b[7:0])
    |=> res.data[7:0] == 8'h00;
  endproperty
  a_cmp_gt: assert property (p_cmp_gt) else $error("greater lane not zero");

  property p_shift_big;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == shift_right_words && b >= 64'h0000000000000010 |=> res.data == '0;
  endproperty
  a_shift_big: assert property (p_shift_big) else $error("big shift not zero");

  property p_sra;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == shift_right_arith_dwords && a[63] && b >= 64'h0000000000000020
    |=> res.data[63:32] == 32'hFFFFFFFF;
  endproperty
  a_sra: assert property (p_sra) else $error("sign fill wrong");

  property p_unpack;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == interleave_low_bytes |=> res.data[15:0] == {$past(b[7:0]), $past(a[7:0])};
  endproperty
  a_unpack: assert property (p_unpack) else $error("low interleave wrong");

  property p_empty;
    @(posedge clk) disable iff (!nrst)
    req.valid && req.op == empty_packed_state |=> regs_empty && regs[0] == '0 && regs[7] == '0;
  endproperty
  a_empty: assert property (p_empty) else $error("state not cleared");

endmodule

`default_nettype wire

/* verification/psd_decoder_model.sv */
// decoder-side model that presents requests to the datapath
`timescale 1ns/1ps
`default_nettype none
module psd_decoder_model
  import psd_pkg::*;
(
  // request toward the datapath
  output var psd_req_t req
);
  initial req = '0;
  // present one request for the coming edge; on idle cycles dst and mem_data
  // change so that nothing downstream can lean on stale fields
  task automatic send(input psd_req_t r);
    if (!r.valid) begin
      r          = req;
      r.valid    = 1'b0;
      r.mem_data = ~req.mem_data;
      r.dst      = req.dst + 3'h1;
    end
    req = r;
  endtask
endmodule
`default_nettype wire

/* verification/packed_integer_simd_datapath_tb.sv */
// self-checking bench of the packed integer simd datapath
`timescale 1ns/1ps
`default_nettype none
module packed_integer_simd_datapath_tb;
  import psd_pkg::*;
  // ----------------------------------------------------------------
  // signals and reference state
  // ----------------------------------------------------------------
  logic        clk  = 1'b0;      // core clock
  logic        nrst = 1'b0;      // async reset
  psd_req_t    req;              // request from the decoder model
  psd_res_t    res;              // result from the datapath
  logic        regs_empty;       // register state empty
  logic [63:0] mregs [8];        // reference register file
  logic        m_empty = 1'b1;   // reference empty flag
  psd_res_t    exp = '0;         // result due at the next edge
  int          n_errors = 0;
  int          samples_checked = 0;
  logic [63:0] pats [6] = '{64'h7FFF_8000_7F80_807F, 64'h8000_7FFF_0080_FF7F, 64'hFFFF_FFFF_FFFF_FFFF,
                            64'h0, 64'h00FF_FF00_0100_FFFE, 64'h7FFF_FFFF_8000_0000};
  psd_decoder_model dec (.req(req));
  psd_datapath DUT (.clk(clk), .nrst(nrst), .req(req), .res(res), .regs_empty(regs_empty));
  // ----------------------------------------------------------------
  // reference arithmetic
  // ----------------------------------------------------------------
  function automatic longint sx(input logic [63:0] v, input int w);
    return longint'(v << (64 - w)) >>> (64 - w);
  endfunction
  function automatic logic [63:0] msk(input int w);
    return (w == 64) ? 64'hFFFF_FFFF_FFFF_FFFF : (64'h1 << w) - 64'h1;
  endfunction
  // clamp to the signed or unsigned range of a lane
  function automatic logic [63:0] sat(input longint v, input int w, input bit s);
    longint lo, hi;
    lo = s ? -(longint'(1) <<< (w - 1)) : 0;
    hi = s ? (longint'(1) <<< (w - 1)) - 1 : (longint'(1) <<< w) - 1;
    return 64'(v > hi ? hi : (v < lo ? lo : v)) & msk(w);
  endfunction
  function automatic logic [63:0] model(input psd_op_t op, input logic [63:0] a, input logic [63:0] b);
    logic [63:0] r, ux, uy, m, v;
    longint      x, y;
    int          w, n;
    case (op)
      move_dword, move_dword_store: return {32'h0, b[31:0]};
      move_qword, move_qword_store: return b;
      quad_bitwise_and:             return a & b;
      quad_bitwise_andnot:          return ~a & b;
      quad_bitwise_or:              return a | b;
      quad_bitwise_xor:             return a ^ b;
      empty_packed_state:           return 64'h0;
      default: ;
    endcase
    w = (op inside {interleave_high_bytes, interleave_low_bytes, lane_add_bytes, lane_add_bytes_ssat,
                    lane_add_bytes_usat, lane_sub_bytes, lane_sub_bytes_ssat, lane_sub_bytes_usat,
                    cmp_equal_bytes, cmp_greater_bytes}) ? 8 :
        (op inside {pack_d2w_signed_sat, interleave_high_dwords, interleave_low_dwords, lane_add_dwords,
                    lane_sub_dwords, cmp_equal_dwords, cmp_greater_dwords, shift_left_dwords,
                    shift_right_dwords, shift_right_arith_dwords}) ? 32 :
        (op inside {shift_left_qword, shift_right_qword}) ? 64 : 16;
    m = msk(w);
    n = 64 / w;
    r = 64'h0;
    for (int i = 0; i < n; i++) begin
      ux = (a >> (i * w)) & m;
      uy = (b >> (i * w)) & m;
      x  = sx(ux, w);
      y  = sx(uy, w);
      v  = 64'h0;
      case (op)
        pack_w2b_signed_sat, pack_d2w_signed_sat:
          r = r | (sat(x, w / 2, 1) << (i * w / 2)) | (sat(y, w / 2, 1) << (32 + i * w / 2));
        pack_w2b_unsigned_sat: r = r | (sat(x, 8, 0) << (i * 8)) | (sat(y, 8, 0) << (32 + i * 8));
        interleave_high_bytes, interleave_high_words, interleave_high_dwords:
          v = ((i % 2) ? b : a) >> ((i / 2 + n / 2) * w);
        interleave_low_bytes, interleave_low_words, interleave_low_dwords:
          v = ((i % 2) ? b : a) >> ((i / 2) * w);
        lane_add_bytes, lane_add_words, lane_add_dwords: v = ux + uy;
        lane_add_bytes_ssat, lane_add_words_ssat: v = sat(x + y, w, 1);
        lane_add_bytes_usat, lane_add_words_usat: v = sat(longint'(ux + uy), w, 0);
        lane_sub_bytes, lane_sub_words, lane_sub_dwords: v = ux - uy;
        lane_sub_bytes_ssat, lane_sub_words_ssat: v = sat(x - y, w, 1);
        lane_sub_bytes_usat, lane_sub_words_usat: v = sat(longint'(ux) - longint'(uy), w, 0);
        mul_words_keep_high: v = 64'((x * y) >>> 16);
        mul_words_keep_low:  v = 64'(x * y);
        mul_words_sum_pairs: r[(i / 2) * 32 +: 32] = r[(i / 2) * 32 +: 32] + 32'(x * y);
        cmp_equal_bytes, cmp_equal_words, cmp_equal_dwords: v = (ux == uy) ? m : 64'h0;
        cmp_greater_bytes, cmp_greater_words, cmp_greater_dwords: v = (x > y) ? m : 64'h0;
        shift_left_words, shift_left_dwords, shift_left_qword:
          v = (b >= 64'(w)) ? 64'h0 : ux << b;
        shift_right_words, shift_right_dwords, shift_right_qword:
          v = (b >= 64'(w)) ? 64'h0 : ux >> b;
        shift_right_arith_words, shift_right_arith_dwords:
          v = (b >= 64'(w)) ? ((x < 0) ? m : 64'h0) : 64'(x >>> b);
        default: v = 64'h0;
      endcase
      r = r | ((v & m) << (i * w));
    end
    return r;
  endfunction
  // ----------------------------------------------------------------
  // checking and driving
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // check the result of the last request, then present the next one
  task automatic step(input psd_req_t r);
    @(posedge clk);
    #1;
    chk("res_valid", {63'h0, exp.valid}, {63'h0, res.valid});
    if (exp.valid) begin
      chk("res_store", {63'h0, exp.store}, {63'h0, res.store});
      chk("res_dst", {61'h0, exp.dst}, {61'h0, res.dst});
      chk("res_data", exp.data, res.data);
    end
    chk("regs_empty", {63'h0, m_empty}, {63'h0, regs_empty});
    dec.send(r);
    exp = '0;
    if (r.valid) begin
      exp.valid = 1'b1;
      exp.store = r.op inside {move_dword_store, move_qword_store};
      exp.dst   = r.dst;
      exp.data  = model(r.op, mregs[r.dst], r.src_mem ? r.mem_data : mregs[r.src]);
      if (r.op == empty_packed_state) begin
        foreach (mregs[k]) mregs[k] = 64'h0;
        m_empty = 1'b1;
      end else if (!exp.store) begin
        mregs[r.dst] = exp.data;
        m_empty      = 1'b0;
      end
    end
  endtask
  task automatic do_reset(input int cycles);
    nrst = 1'b0;
    repeat (cycles) @(posedge clk);
    #1;
    chk("reset_data", 64'h0, res.data);
    chk("reset_empty", 64'h1, {63'h0, regs_empty});
    // idle request goes out after the reset cycles, never in the same step as the last one
    dec.send('0);
    nrst = 1'b1;
    foreach (mregs[k]) mregs[k] = 64'h0;
    m_empty = 1'b1;
    exp     = '0;
  endtask
  // random request; counts near lane widths and clamp-edge patterns are favoured
  function automatic psd_req_t rnd();
    psd_req_t r;
    r.valid   = ($urandom_range(0, 7) != 0);
    r.op      = psd_op_t'($urandom_range(0, 48));
    r.dst     = 3'($urandom_range(0, 7));
    r.src     = 3'($urandom_range(0, 7));
    r.src_mem = 1'($urandom_range(0, 1));
    case ($urandom_range(0, 3))
      0:       r.mem_data = pats[$urandom_range(0, 5)];
      1:       r.mem_data = 64'($urandom_range(0, 70));
      default: r.mem_data = {$urandom, $urandom};
    endcase
    return r;
  endfunction
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h0206));
    #1;
    do_reset(10);
    for (int k = 0; k < 8; k++) begin
      step('{1'b1, move_qword, 3'(k), 3'h0, 1'b1, pats[k % 6]});
    end
    for (int t = 0; t < 3000; t++) begin
      if (t == 1500) begin
        do_reset(2);
      end
      step(rnd());
    end
    step('0);
    step('0);
    report_and_stop();
  end
endmodule
`default_nettype wire
